//--- rtl/eipd_cfg.svh
// Constants for the external interrupt pair detector.
// Assumes inclusion by the package and the design module only.
`ifndef EIPD_CFG_SVH
`define EIPD_CFG_SVH
`define EIPD_PIN_SEL_W     3
`define EIPD_PIN_COUNT     8
`define EIPD_CTRL_W        8
`define EIPD_A_PEND_BIT    1
`define EIPD_B_PEND_BIT    3
`define EIPD_SEL_RESET     3'h0
`define EIPD_CTRL_RESET    8'h00
`define EIPD_SYNC_RESET    2'h0
`endif

//--- rtl/eipd_pkg.sv
// Types shared by the external interrupt pair detector.
// Assumes eipd_cfg.svh is on the include path.
`include "eipd_cfg.svh"
package eipd_pkg;
   typedef struct packed {
      logic                       edgeSelect;
      logic                       polarity;
      logic [`EIPD_PIN_SEL_W-1:0] pinSelect;
   } eipd_chan_cfg_t;
   typedef enum logic [1:0] {
      EIPD_LOW_LEVEL  = 2'h0,
      EIPD_HIGH_LEVEL = 2'h1,
      EIPD_LOW_EDGE   = 2'h2,
      EIPD_HIGH_EDGE  = 2'h3
   } eipd_mode_t;
endpackage

//--- rtl/eipd_detect.sv
// Two external interrupt inputs watching selectable port pins.
// Assumes pins are synchronous, vector acks are one-cycle pulses from the CPU.
// Assumes the configuration comes from registers held outside this block.
// Changing polarity or mode reinterprets the held pin and may itself flag an edge.
// The pending flags reach the ports one registered stage after detection.
// Overview of operation
// - Each input has a polarity bit choosing active-high or active-low pin state.
// - Each input has a bit choosing edge or level detection.
// - Edge bit 1 means edge, 0 level; polarity 1 high, 0 low.
// - Watched pin chosen by configuration select, independent of crossbar routing.
// - Monitoring only reads the pin and never disturbs its peripheral.
// - Pending flags sit at bits 1 and 3 of the control byte.
// - Edge mode pending clears when the CPU vectors to the routine.
// - Level mode pending equals whether the input is currently active.
// - In level mode, input still active after servicing raises another request.
`timescale 1ns/1ps
`default_nettype none
`include "eipd_cfg.svh"

module eipd_detect (
   input  wire logic                          clk,
   input  wire logic                          reset,
   input  wire logic [`EIPD_PIN_COUNT-1:0]    portPins,
   input  wire eipd_pkg::eipd_chan_cfg_t      cfgA,
   input  wire eipd_pkg::eipd_chan_cfg_t      cfgB,
   input  wire logic                          vectorAckA,
   input  wire logic                          vectorAckB,
   output logic                               irqAPending,
   output logic                               irqBPending,
   output logic [`EIPD_CTRL_W-1:0]            timerIrqControlReg
);

   localparam logic [`EIPD_CTRL_W-1:0] CtrlReset = `EIPD_CTRL_RESET;

   eipd_pkg::eipd_chan_cfg_t cfg [2];

   logic                     ack [2];

   logic                     pend_q [2];

   assign cfg[0] = cfgA;
   assign cfg[1] = cfgB;

   assign ack[0] = vectorAckA;
   assign ack[1] = vectorAckB;

   // Observing a pin is a pure read; nothing is driven back onto the port.
   genvar i;
   generate
      for (i = 0; i < 2; i++) begin : gChan
         logic [1:0]           sync_q;

         logic [1:0]           sync_d;

         logic                 prev_q;

         logic                 prev_d;

         logic                 pend_d;

         logic                 setPend;

         logic                 clearPend;

         logic                 rawPin;

         logic                 active;

         logic                 rising;

         logic                 isEdge;

         logic                 activeHigh;

         eipd_pkg::eipd_mode_t mode;

         assign rawPin = portPins[cfg[i].pinSelect];

         assign mode = eipd_pkg::eipd_mode_t'({cfg[i].edgeSelect, cfg[i].polarity});

         always_comb begin
            isEdge     = 1'b0;
            activeHigh = 1'b0;

            unique case (mode)
               eipd_pkg::EIPD_LOW_LEVEL: begin
                  isEdge     = 1'b0;
                  activeHigh = 1'b0;
               end

               eipd_pkg::EIPD_HIGH_LEVEL: begin
                  isEdge     = 1'b0;
                  activeHigh = 1'b1;
               end

               eipd_pkg::EIPD_LOW_EDGE: begin
                  isEdge     = 1'b1;
                  activeHigh = 1'b0;
               end

               eipd_pkg::EIPD_HIGH_EDGE: begin
                  isEdge     = 1'b1;
                  activeHigh = 1'b1;
               end
            endcase
         end

         // Only the second flop feeds detection, so a changing pin is never read twice.
         always_comb begin
            sync_d = {sync_q[0], rawPin};
         end

         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               sync_q <= `EIPD_SYNC_RESET;
            end else begin
               sync_q <= sync_d;
            end
         end

         assign active = activeHigh ? sync_q[1] : ~sync_q[1];

         always_comb begin
            prev_d = active;
         end

         // Reset to active; an active-low pin held active through reset gives no edge, an active-high one does.
         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               prev_q <= 1'b1;
            end else begin
               prev_q <= prev_d;
            end
         end

         assign rising = active && !prev_q;

         assign setPend = isEdge && rising;

         assign clearPend = isEdge && ack[i] && !rising;

         // A new edge in the ack cycle wins over the clear so no event is lost.
         always_comb begin
            pend_d = pend_q[i];
            if (!isEdge) begin
               pend_d = active;
            end else if (setPend) begin
               pend_d = 1'b1;
            end else if (clearPend) begin
               pend_d = 1'b0;
            end
         end

         // Pending flag of this channel.
         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               pend_q[i] <= 1'b0;
            end else begin
               pend_q[i] <= pend_d;
            end
         end
      end
   endgenerate

   logic [`EIPD_CTRL_W-1:0] ctrl_d;

   logic                    irqAPending_d;

   logic                    irqBPending_d;

   // Spare bits hold their reset value so software always reads them as zero.
   genvar j;
   generate
      for (j = 0; j < `EIPD_CTRL_W; j++) begin : gCtrlBit
         if (j == `EIPD_A_PEND_BIT) begin : gA
            assign ctrl_d[j] = pend_q[0];
         end else if (j == `EIPD_B_PEND_BIT) begin : gB
            assign ctrl_d[j] = pend_q[1];
         end else begin : gSpare
            assign ctrl_d[j] = CtrlReset[j];
         end
      end
   endgenerate

   always_comb begin
      irqAPending_d = pend_q[0];
   end

   always_comb begin
      irqBPending_d = pend_q[1];
   end

   // Outputs come straight from flops; this costs one cycle of latency.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         irqAPending <= 1'b0;
      end else begin
         irqAPending <= irqAPending_d;
      end
   end

   // Channel B pending as seen by the CPU.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         irqBPending <= 1'b0;
      end else begin
         irqBPending <= irqBPending_d;
      end
   end

   // Control byte image with both pending bits in place.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         timerIrqControlReg <= `EIPD_CTRL_RESET;
      end else begin
         timerIrqControlReg <= ctrl_d;
      end
   end
endmodule
`default_nettype wire

//--- verif/eipd_detect_props.sv
// Port checks for the pair detector; events are judged only while the config holds still.
`timescale 1ns/1ps
`default_nettype none
module eipd_detect_props (
   input wire logic                     clk,
   input wire logic                     reset,
   input wire logic                     vectorAckA,
   input wire logic                     vectorAckB,
   input wire logic                     irqAPending,
   input wire logic                     irqBPending,
   input wire logic [7:0]               portPins,
   input wire logic [7:0]               timerIrqControlReg,
   input wire eipd_pkg::eipd_chan_cfg_t cfgA,
   input wire eipd_pkg::eipd_chan_cfg_t cfgB
);
   wire logic aOn = portPins[cfgA.pinSelect] ~^ cfgA.polarity;
   wire logic bOn = portPins[cfgB.pinSelect] ~^ cfgB.polarity;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   AST_A_BIT: assert property (timerIrqControlReg[1] == irqAPending) else $error("bit1");
   AST_B_BIT: assert property (timerIrqControlReg[3] == irqBPending) else $error("bit3");
   AST_SPARE: assert property (!(timerIrqControlReg & 8'hF5)) else $error("spare");
   AST_A_LVL: assert property (($stable(cfgA) && !cfgA.edgeSelect)[*5]
      |-> irqAPending == $past(aOn, 4)) else $error("A lvl");
   AST_B_LVL: assert property (($stable(cfgB) && !cfgB.edgeSelect)[*5]
      |-> irqBPending == $past(bOn, 4)) else $error("B lvl");
   AST_A_ACK: assert property ((cfgA.edgeSelect && $stable(cfgA) && !aOn)[*4] ##0 vectorAckA
      |-> ##2 !irqAPending) else $error("A ack");
   AST_B_ACK: assert property ((cfgB.edgeSelect && $stable(cfgB) && !bOn)[*4] ##0 vectorAckB
      |-> ##2 !irqBPending) else $error("B ack");
   AST_A_EDGE: assert property ((cfgA.edgeSelect && $stable(cfgA) && !aOn)[*3]
      ##1 (aOn && $stable(cfgA)) ##1 ($stable(cfgA) && !vectorAckA)[*4]
      |-> irqAPending) else $error("A edge");
endmodule
bind eipd_detect eipd_detect_props u_eipd_detect_props (.clk(clk), .reset(reset),
   .vectorAckA(vectorAckA), .vectorAckB(vectorAckB), .irqAPending(irqAPending),
   .irqBPending(irqBPending), .portPins(portPins), .timerIrqControlReg(timerIrqControlReg),
   .cfgA(cfgA), .cfgB(cfgB));
`default_nettype wire

//--- verif/eipd_src.sv
// Pin source model; assumes the bench sets each wanted level off the clock edge.
`timescale 1ns/1ps
`default_nettype none
module eipd_src (
   input  wire logic [7:0] want,
   output logic      [7:0] portPins);
   // Pins follow the wanted levels at once; the model holds nothing and sees no flag or ack.
   assign portPins = want;
endmodule
`default_nettype wire

//--- verif/eipd_detect_tb.sv
// Bench for the pair detector: every mode on both channels; assumes the source model.
`timescale 1ns/1ps
`default_nettype none
module eipd_detect_tb;
   logic                     clk = 1'h0, reset = 1'h1, ack = 1'h0, pA, pB;
   logic [7:0]               want = 8'hFF, pins, ctrl;
   eipd_pkg::eipd_chan_cfg_t cfgA = 5'h00, cfgB = 5'h00;
   int                       fail_count = 0, cmp_count = 0, cyc = 0, m;
   eipd_src u_eipd_src (.want(want), .portPins(pins));
   eipd_detect u_eipd_detect (.clk(clk), .reset(reset), .portPins(pins), .cfgA(cfgA),
      .cfgB(cfgB), .vectorAckA(ack), .vectorAckB(ack), .irqAPending(pA), .irqBPending(pB),
      .timerIrqControlReg(ctrl));
   initial forever #25 clk = ~clk;
   initial #1000 reset = 1'h0;
   always @(posedge clk) if (++cyc == 500) begin
      fail_count++;
      summarize();
   end
   task automatic summarize;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Only pins m and m+4 carry the level, so a wrong pin pick shows up.
   task automatic step(input logic act, ak, input int n, input logic e);
      want = {8{act ^ cfgA.polarity}} ^ (8'h11 << m);
      repeat (n) @(negedge clk);
      ack = ak;
      repeat (4) @(negedge clk) ack = 1'h0;
      cmp_count++;
      if ({pA, pB, ctrl} !== {e, e, 4'h0, e, 1'h0, e, 1'h0}) begin
         fail_count++;
         $display("mismatch %0t pending", $time);
      end
   endtask
   initial begin
      #1000;
      for (m = 0; m < 4; m++) begin
         cfgA = {m[1], m[0], 3'(m)};
         cfgB = {m[1], m[0], 3'(m + 4)};
         step(1'h0, 1'h1, 8, 1'h0);
         step(1'h1, 1'h0, 6, 1'h1);
         step(1'h1, 1'h1, 1, ~m[1]);
         step(1'h0, 1'h0, 6, 1'h0);
      end
      summarize();
   end
endmodule
`default_nettype wire
